// ---- rtl/piso_cfg.svh ----
// Constants for the latched parallel/serial-in, serial-out shift register.
// Assumes inclusion by bare name from rtl/ files only.
`ifndef PISO_CFG_SVH
`define PISO_CFG_SVH
`define PISO_WIDTH 8
`define PISO_LATCH_RESET 8'h00
`define PISO_STAGE_RESET 8'h00
`define PISO_SYNC_STAGES 2
`endif

// ---- rtl/piso_pkg.sv ----
// Types for the latched shift register.
// Assumes piso_cfg.svh is on the include path.
`include "piso_cfg.svh"
package piso_pkg;
    typedef logic [`PISO_WIDTH-1:0] byte_t;
    typedef enum logic [1:0] {
        MODE_HOLD = 2'b00,
        MODE_SHIFT = 2'b01,
        MODE_COPY = 2'b10,
        MODE_LOAD = 2'b11
    } stage_op_t;
endpackage : piso_pkg

// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser bank for pins from outside the ref_clk domain.
// Assumes asynchronous pins; first flop feeds only the second.
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_out
);
    logic [WIDTH-1:0] meta_q;

    // Refuse an empty bank at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync WIDTH must be positive");
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            pin_sync_out <= '0;
        end else if (clk_en) begin
            meta_q <= pin_in;
            pin_sync_out <= meta_q;
        end
    end
endmodule : pin_sync

// ---- rtl/latched_piso_shift_register.sv ----
// Latched parallel/serial-in, serial-out shift register, sampled on ref_clk.
// Assumes all pins are asynchronous; pin clocks are edge-detected after sync,
// so each pin level must stand at least three ref_clk cycles.
`include "piso_cfg.svh"
module latched_piso_shift_register
    import piso_pkg::*;
#(
    parameter int WIDTH = `PISO_WIDTH
) (
    // Clock, enable, reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Parallel and serial data pins
    input wire logic [WIDTH-1:0] par_in,
    input wire logic ser_in,
    // Control pins
    input wire logic shift_mode,
    input wire logic latch_clk,
    input wire logic shift_clk,
    input wire logic out_en_n,
    // Three-state serial output
    output logic ser_out,
    output logic ser_out_oe,
    // Observation of stored state
    output logic [WIDTH-1:0] latch_bits,
    output logic [WIDTH-1:0] shift_stages
);
    import piso_pkg::*;

    // Position of each pin inside the synchroniser bank
    localparam int PAR_LO = 0;
    localparam int SER_BIT = WIDTH;
    localparam int MODE_BIT = WIDTH + 1;
    localparam int LCLK_BIT = WIDTH + 2;
    localparam int SCLK_BIT = WIDTH + 3;
    localparam int OE_BIT = WIDTH + 4;
    localparam int NSYNC = WIDTH + 5;

    // The stage chain and the observation ports are laid out for eight stages
    if (WIDTH != `PISO_WIDTH) begin : g_bad_width
        $error("WIDTH must be eight");
    end

    // The edge timing of the whole block assumes a two-flop bank
    if (`PISO_SYNC_STAGES != 2) begin : g_bad_sync
        $error("synchroniser depth must be two");
    end

    // Rising edge of a synchronised pin against its value one cycle before
    function automatic logic rise_of(input logic now_v, input logic prev_v);
        return now_v && !prev_v;
    endfunction : rise_of

    // Source of one stage for the operation chosen this cycle
    function automatic logic stage_pick(
        input stage_op_t sel,
        input logic hold_v,
        input logic shift_v,
        input logic copy_v,
        input logic load_v
    );
        logic pick_v;
        pick_v = hold_v;
        case (sel)
            MODE_HOLD: pick_v = hold_v;
            MODE_SHIFT: pick_v = shift_v;
            MODE_COPY: pick_v = copy_v;
            MODE_LOAD: pick_v = load_v;
            default: pick_v = hold_v;
        endcase
        return pick_v;
    endfunction : stage_pick

    // Raw pin bank and its synchronised copy
    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] pins_s;

    // Synchronised pins
    logic [WIDTH-1:0] par_s;
    logic ser_s;
    logic mode_s;
    logic lclk_s;
    logic sclk_s;
    logic oe_s;

    // Enable carried active high through the bank
    logic out_en_pin;

    // Edge history and detected edges
    logic lclk_prev_q;
    logic sclk_prev_q;
    logic latch_edge;
    logic shift_edge;

    // Operation decode
    logic mode_low;
    logic load_now;
    logic copy_now;
    logic shift_now;
    stage_op_t op;

    // Next values of the stored state
    logic [WIDTH-1:0] latch_d;
    logic [WIDTH-1:0] stages_d;

    // Inverting before the bank makes the reset value of the bank mean
    // "not driving", so the pin floats during reset and the first cycles after
    assign out_en_pin = !out_en_n;

    assign pins_raw = {out_en_pin, shift_clk, latch_clk, shift_mode, ser_in, par_in};

    pin_sync #(
        .WIDTH(NSYNC)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_in(pins_raw),
        .pin_sync_out(pins_s)
    );

    assign par_s = pins_s[PAR_LO +: WIDTH];
    assign ser_s = pins_s[SER_BIT];
    assign mode_s = pins_s[MODE_BIT];
    assign lclk_s = pins_s[LCLK_BIT];
    assign sclk_s = pins_s[SCLK_BIT];
    assign oe_s = pins_s[OE_BIT];

    // Rising edges only; falling edges of either pin clock do nothing
    assign latch_edge = rise_of(lclk_s, lclk_prev_q);
    assign shift_edge = rise_of(sclk_s, sclk_prev_q);

    // Mode low overrides the shift clock and ignores the serial input
    assign mode_low = !mode_s;
    assign load_now = mode_low && latch_edge;
    assign copy_now = mode_low && !latch_edge;
    assign shift_now = !mode_low && shift_edge;

    // One operation per cycle for the stage chain
    assign op = load_now ? MODE_LOAD
              : copy_now ? MODE_COPY
              : shift_now ? MODE_SHIFT
              : MODE_HOLD;

    // Stage 0 is A, the top stage is H; A takes the serial input on a shift
    for (genvar gi = 0; gi < WIDTH; gi++) begin : g_stage
        logic shift_src;

        if (gi == 0) begin : g_first
            assign shift_src = ser_s;
        end else begin : g_next
            assign shift_src = shift_stages[gi-1];
        end

        // Copy takes the stored latch bit, so a latch edge in the same cycle
        // under mode low goes through the load branch instead
        assign stages_d[gi] = stage_pick(op, shift_stages[gi], shift_src,
                                         latch_bits[gi], par_s[gi]);

        // Latch moves only on its own edge, in any mode
        assign latch_d[gi] = latch_edge ? par_s[gi] : latch_bits[gi];
    end

    // Edge history; frozen with the bank so no false edge appears on resume
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lclk_prev_q <= 1'b0;
            sclk_prev_q <= 1'b0;
        end else if (clk_en) begin
            lclk_prev_q <= lclk_s;
            sclk_prev_q <= sclk_s;
        end
    end

    // Stored state; the output enable plays no part here
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_bits <= `PISO_LATCH_RESET;
            shift_stages <= `PISO_STAGE_RESET;
        end else if (clk_en) begin
            latch_bits <= latch_d;
            shift_stages <= stages_d;
        end
    end

    // Output stage always carries H; the enable only gates the driver
    assign ser_out = shift_stages[WIDTH-1];

    // Driver on while the synchronised enable is low at the pin
    assign ser_out_oe = oe_s;

endmodule : latched_piso_shift_register

// ---- dv/piso_asserts.sv ----
// Pin-level checks for the latched shift register.
// Assumes clk_en high and every pin level held three ref_clk cycles.
module piso_asserts #(parameter int WIDTH = 8) (
    input wire logic ref_clk, rst_n, clk_en, latch_clk, shift_clk, shift_mode, ser_in, out_en_n, ser_out, ser_out_oe,
    input wire logic [WIDTH-1:0] par_in, latch_bits, shift_stages
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    // Pin history is not frozen with the block, so checks pause with it
    default disable iff (!rst_n || !clk_en);
    // Pin history: a rise between bits 3 and 2 has just acted
    logic [3:0] lc_q, sc_q;
    always_ff @(posedge ref_clk) begin
        lc_q <= {lc_q[2:0], latch_clk};
        sc_q <= {sc_q[2:0], shift_clk};
    end
    property p_off; out_en_n[*3] |-> !ser_out_oe; endproperty
    a_off: assert property (p_off) else $error("oe on");
    property p_on; !out_en_n[*3] |-> ser_out_oe; endproperty
    a_on: assert property (p_on) else $error("oe off");
    property p_cap; lc_q[3:2] == 2'h1 |-> latch_bits == $past(par_in, 3); endproperty
    a_cap: assert property (p_cap) else $error("capture");
    property p_keep; lc_q[3:2] != 2'h1 |-> $stable(latch_bits); endproperty
    a_keep: assert property (p_keep) else $error("latch moved");
    property p_load; lc_q[3:2] == 2'h1 && !$past(shift_mode, 3) |-> shift_stages == $past(par_in, 3); endproperty
    a_load: assert property (p_load) else $error("load");
    property p_shift; sc_q[3:2] == 2'h1 && $past(shift_mode, 3)
        |-> shift_stages == {$past(shift_stages[WIDTH-2:0]), $past(ser_in, 3)}; endproperty
    a_shift: assert property (p_shift) else $error("shift");
    property p_copy; (!shift_mode && !latch_clk)[*5] |-> shift_stages == latch_bits; endproperty
    a_copy: assert property (p_copy) else $error("copy");
    property p_out; ser_out == shift_stages[WIDTH-1]; endproperty
    a_out: assert property (p_out) else $error("stage H");
    c_both: cover property (lc_q[3:2] == 2'h1 && sc_q[3:2] == 2'h1);
    c_load: cover property (lc_q[3:2] == 2'h1 && !shift_mode);
    c_float: cover property ($fell(ser_out_oe));
endmodule : piso_asserts
bind latched_piso_shift_register piso_asserts #(.WIDTH(WIDTH)) chk (.*);

// ---- dv/spi_reader.sv ----
// Host reader clocking a byte out, high bit first.
// Assumes the block acts on a pin edge within three ref_clk cycles.
module spi_reader (
    input wire logic ref_clk, ser_out, ser_out_oe,
    output logic shift_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last = 1'h0;
    initial shift_clk = 1'h0;
    // A floating line reads as the inverse of the last bit
    task automatic read(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            repeat (4) @(posedge ref_clk);
            #1;
            b[i] = ser_out_oe ? ser_out : ~last;
            last = b[i];
            shift_clk = i > 0;
            repeat (4) @(posedge ref_clk);
            #1 shift_clk = 1'h0;
        end
    endtask : read
endmodule : spi_reader

// ---- dv/tb_latched_piso_shift_register.sv ----
// Bench: parallel loads read back serially, then corner cases.
// Assumes pins held three cycles; clk_en high except in the frozen-block check.
module tb_latched_piso_shift_register;
    import piso_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'h0, rst_n = 1'h0, ser_in = 1'h0, shift_mode = 1'h0, latch_clk = 1'h0, out_en_n = 1'h0;
    logic shift_clk, ser_out, ser_out_oe, clk_en = 1'h1;
    byte_t par_in = 8'h00, latch_bits, shift_stages, got;
    byte_t rows [3] = '{8'hA5, 8'h3C, 8'h80};
    int failures = 0, checks = 0;
    always #5 ref_clk = ~ref_clk;
    latched_piso_shift_register DUT (.ref_clk, .rst_n, .clk_en, .par_in, .ser_in, .shift_mode,
        .latch_clk, .shift_clk, .out_en_n, .ser_out, .ser_out_oe, .latch_bits, .shift_stages);
    spi_reader R (.ref_clk, .ser_out, .ser_out_oe, .shift_clk);
    task automatic step(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic cmp(byte_t g, byte_t e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: %h vs %h", $time, g, e);
        end
    endtask : cmp
    // Shift pulse rides with the latch pulse when s is set
    task automatic latch(byte_t d, logic m, logic s);
        par_in = d;
        shift_mode = m;
        step(4);
        latch_clk = 1'h1;
        R.shift_clk = s;
        step(4);
        latch_clk = 1'h0;
        R.shift_clk = 1'h0;
        step(4);
    endtask : latch
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    initial begin
        step(16);
        cmp({7'h00, ser_out_oe}, 8'h00);
        rst_n = 1'h1;
        step(3);
        foreach (rows[i]) begin
            latch(rows[i], 1'h0, 1'h0);
            shift_mode = 1'h1;
            R.read(got);
            cmp(got, rows[i]);
        end
        latch(8'h5A, 1'h1, 1'h0);
        cmp(shift_stages, 8'h00);
        cmp(latch_bits, 8'h5A);
        out_en_n = 1'h1;
        shift_mode = 1'h0;
        step(5);
        cmp(shift_stages, 8'h5A);
        cmp({7'h00, ser_out_oe}, 8'h00);
        ser_in = 1'h1;
        latch(8'hC3, 1'h1, 1'h1);
        cmp(shift_stages, 8'hB5);
        cmp(latch_bits, 8'hC3);
        // Frozen block must ignore both pin clocks entirely
        clk_en = 1'h0;
        latch(8'h11, 1'h1, 1'h1);
        clk_en = 1'h1;
        step(4);
        cmp(latch_bits, 8'hC3);
        cmp(shift_stages, 8'hB5);
        wrap_up();
    end
    initial begin
        #50000;
        failures++;
        wrap_up();
    end
endmodule : tb_latched_piso_shift_register
